// ### include/idx_ops_pkg.sv
// package: opcodes, flag positions, timing and carrier types for the index/transfer unit
//
// Operation
// RQ1: index pointer from two 8-bit halves
// RQ2: indexed addresses use full 16-bit pointer
// RQ3: some instructions touch only low half
// RQ4: low half is general data register
// RQ5: transfers move data between accumulator, low half
// RQ6: reset clears upper half, keeps lower
// RQ7: opcode 97 copies accumulator to low half
// RQ8: test sets N,Z, clears V, stores nothing
// RQ9: opcode 95 loads pointer with stack+1
// RQ10: opcode 94 loads stack with pointer-1
// RQ11: opcode 8F clears mask, waits for interrupt
// RQ12: cycles counted in bus clocks, half rate
// RQ13: 84 loads flags, 85 reads flags
// RQ14: opcode 9F copies low half to accumulator
package idx_ops_pkg;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ACC_TO_FLAGS    = 8'h84;
    localparam logic [7:0] OP_FLAGS_TO_ACC    = 8'h85;
    localparam logic [7:0] OP_PTR_TO_STACK    = 8'h94;
    localparam logic [7:0] OP_STACK_TO_PTR    = 8'h95;
    localparam logic [7:0] OP_ACC_TO_LOW      = 8'h97;
    localparam logic [7:0] OP_LOW_TO_ACC      = 8'h9f;
    localparam logic [7:0] OP_WAIT_IRQ        = 8'h8f;
    localparam logic [7:0] OP_TEST_DIR        = 8'h3d;
    localparam logic [7:0] OP_TEST_ACC        = 8'h4d;
    localparam logic [7:0] OP_TEST_LOW        = 8'h5d;
    localparam logic [7:0] OP_TEST_IX1        = 8'h6d;
    localparam logic [7:0] OP_TEST_IX         = 8'h7d;
    localparam logic [7:0] OP_PAGE2           = 8'h9e;
    localparam logic [7:0] OP_TEST_SP1        = 8'h6d;
    // low-half data ops (inherent, X form)
    localparam logic [7:0] OP_LOW_CLEAR       = 8'h5f;
    localparam logic [7:0] OP_LOW_INC         = 8'h5c;
    localparam logic [7:0] OP_LOW_DEC         = 8'h5a;
    localparam logic [7:0] OP_LOW_COM         = 8'h53;
    localparam logic [7:0] OP_LOW_NEG         = 8'h50;
    localparam logic [7:0] OP_LOW_LSL         = 8'h58;
    localparam logic [7:0] OP_LOW_LSR         = 8'h54;
    localparam logic [7:0] OP_LOW_ROL         = 8'h59;
    localparam logic [7:0] OP_LOW_ROR         = 8'h56;

    // ------------------------------------------------------------
    // condition code bit positions
    // ------------------------------------------------------------
    localparam int unsigned CC_C = 0;
    localparam int unsigned CC_Z = 1;
    localparam int unsigned CC_N = 2;
    localparam int unsigned CC_I = 3;
    localparam int unsigned CC_H = 4;
    localparam int unsigned CC_V = 7;
    localparam logic [7:0]  CC_FIXED_ONES = 8'h60;   // bits 6:5 forced to one when flags are loaded from the accumulator

    // ------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0]  HIGH_RESET   = 8'h00;
    localparam logic [15:0] PTR_STEP     = 16'h0001;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [7:0]  CC_RESET     = 8'h68;    // mask set after reset

    // ------------------------------------------------------------
    // timing: core clock 100 MHz, bus clock half of it
    // ------------------------------------------------------------
    localparam int unsigned CORE_PERIOD_NS = 10;
    localparam int unsigned BUS_DIV        = 2;
    localparam int unsigned CYC_ONE        = 1;      // bus cycles, single-cycle ops
    localparam int unsigned CYC_TWO        = 2;      // bus cycles, pointer moves and wait

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;     // start the instruction
        logic [7:0] opcode;    // opcode byte after any prefix
        logic       page2;     // prefix byte seen
        logic [7:0] operand;   // memory operand for test forms
    } instr_req_t;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  cc;
        logic [15:0] stack_pointer;
    } core_regs_t;

endpackage : idx_ops_pkg

// ### src/bus_clk_div.sv
// bus clock enable divider: one pulse per bus clock
`timescale 1ns/1ns
module bus_clk_div
    import idx_ops_pkg::*;
#(
    parameter int unsigned DIV = BUS_DIV
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic arst_n,
    // enable out
    output logic      bus_en
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_reg;   // position in the bus clock
    wire           wrap = (cnt_reg == LAST);

    // ------------------------------------------------------------
    // counter, pulse on wrap
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            bus_en  <= 1'b0;
        end else begin
            cnt_reg <= wrap ? '0 : cnt_reg + CW'(1);
            bus_en  <= wrap; // RQ12
        end
    end
endmodule : bus_clk_div

// ### src/index_reg_transfer_ops.sv
// index pointer and transfer/test/wait instruction unit
`timescale 1ns/1ns
module index_reg_transfer_ops
    import idx_ops_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // instruction request
    input  instr_req_t       req,
    input  wire logic        irq_pending,
    // core register image in
    input  core_regs_t       regs_in,
    input  wire logic [7:0]  offset8,
    // results
    output core_regs_t       regs_out,
    output logic [7:0]       index_high,
    output logic [7:0]       index_low,
    output logic [15:0]      eff_addr,
    output logic             busy,
    output logic             halted,
    output logic             done
);
    // ------------------------------------------------------------
    // bus clock enable
    // ------------------------------------------------------------
    // every cycle count below is in bus clocks, so counting and waking wait on this; a request is taken on any core clock
    // the divider lives apart so the bus rate can change without touching this unit
    logic bus_en;                // one-cycle pulse per bus clock
    bus_clk_div #(.DIV(BUS_DIV)) u_div (
        .mclk   (mclk),
        .arst_n (arst_n),
        .bus_en (bus_en)
    );

    // ------------------------------------------------------------
    // sequencer state and latched request
    // ------------------------------------------------------------
    // idle takes a request, exec counts bus cycles, wait sleeps until an interrupt
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} state_t;
    state_t      state_reg;      // sequencer state
    logic [1:0]  cyc_reg;        // bus cycles left
    logic [7:0]  op_reg;         // latched opcode
    logic        pg2_reg;        // latched prefix
    logic [7:0]  opnd_reg;       // latched memory operand
    logic [7:0]  low_reg;        // not reset: value survives reset
    logic [7:0]  high_reg;       // upper half, cleared by reset

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // bus clocks per opcode; anything unrecognised finishes in one
    function automatic logic [1:0] bus_cycles(input logic [7:0] op);
        case (op)
            OP_STACK_TO_PTR, OP_PTR_TO_STACK, OP_WAIT_IRQ: bus_cycles = 2'(CYC_TWO);
            default:                                      bus_cycles = 2'(CYC_ONE);
        endcase
    endfunction : bus_cycles

    // memory-operand test forms, the prefixed stack-relative one included
    function automatic logic is_test_mem(input logic [7:0] op, input logic pg);
        is_test_mem = (!pg && (op == OP_TEST_DIR || op == OP_TEST_IX1 || op == OP_TEST_IX))
                      || (pg && op == OP_TEST_SP1);
    endfunction : is_test_mem

    // pointer moves stay 16 bits wide so the carry between the halves is kept
    wire [15:0] ptr      = {high_reg, low_reg};                      // RQ1
    wire [15:0] ptr_inc  = regs_in.stack_pointer + PTR_STEP;         // RQ9
    wire [15:0] ptr_dec  = ptr - PTR_STEP;                           // RQ10
    wire        start    = (state_reg == ST_IDLE) && req.valid;
    wire        last_cyc = bus_en && (cyc_reg == 2'd1);
    wire        exec_end = (state_reg == ST_EXEC) && last_cyc;
    // an interrupt ends the sleep only on a bus clock, like each exec count step
    wire        wake     = (state_reg == ST_WAIT) && irq_pending && bus_en;
    // pointer plus optional offset for the indexed test forms
    wire [15:0] ix_addr  = (op_reg == OP_TEST_IX) ? ptr : ptr + {8'h00, offset8}; // RQ2

    // limitation: the memory test forms take one bus clock here, because the
    // operand byte arrives with the request instead of being fetched
    // test source: accumulator, low half or memory
    wire [7:0] test_val = (!pg2_reg && op_reg == OP_TEST_ACC) ? regs_in.acc :
                          (!pg2_reg && op_reg == OP_TEST_LOW) ? low_reg : opnd_reg;
    wire       is_test  = (!pg2_reg && (op_reg == OP_TEST_ACC || op_reg == OP_TEST_LOW))
                          || is_test_mem(op_reg, pg2_reg);

    // low-half data ops, upper half untouched
    // the upper half never enters this path, which is what keeps it intact
    logic [7:0] low_alu;         // result for the lower half
    logic       low_alu_hit;     // opcode is one of the lower-half data ops
    logic       low_carry;       // carry defaults to the incoming flag
    always_comb begin
        low_alu     = low_reg;
        low_alu_hit = !pg2_reg;
        low_carry   = regs_in.cc[CC_C];
        case (op_reg)
            OP_LOW_CLEAR: low_alu = BYTE_ZERO;                                  // RQ4
            OP_LOW_INC:   low_alu = low_reg + 8'h01;                             // RQ4
            OP_LOW_DEC:   low_alu = low_reg - 8'h01;                             // RQ4
            OP_LOW_COM:   begin low_alu = ~low_reg; low_carry = 1'b1; end       // RQ4
            OP_LOW_NEG:   begin
                low_alu   = BYTE_ZERO - low_reg;                                 // RQ4
                low_carry = (low_reg != BYTE_ZERO);
            end
            OP_LOW_LSL:   begin low_alu = {low_reg[6:0], 1'b0}; low_carry = low_reg[7]; end
            OP_LOW_LSR:   begin low_alu = {1'b0, low_reg[7:1]}; low_carry = low_reg[0]; end
            OP_LOW_ROL:   begin
                low_alu   = {low_reg[6:0], regs_in.cc[CC_C]};
                low_carry = low_reg[7];
            end
            OP_LOW_ROR:   begin
                low_alu   = {regs_in.cc[CC_C], low_reg[7:1]};
                low_carry = low_reg[0];
            end
            default:      low_alu_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // a request is taken only while idle; one that arrives while busy is ignored
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            cyc_reg   <= '0;
            op_reg    <= BYTE_ZERO;
            pg2_reg   <= 1'b0;
            opnd_reg  <= BYTE_ZERO;
        end else begin
            case (state_reg)
                // latch the request so later changes on req cannot disturb it
                ST_IDLE: if (start) begin
                    state_reg <= ST_EXEC;
                    op_reg    <= req.opcode;
                    pg2_reg   <= req.page2;
                    opnd_reg  <= req.operand;
                    cyc_reg   <= bus_cycles(req.opcode);                 // RQ12
                end
                // count down bus clocks; the wait opcode then goes to sleep
                ST_EXEC: if (bus_en) begin
                    cyc_reg <= cyc_reg - 2'd1;
                    if (cyc_reg == 2'd1)
                        state_reg <= (op_reg == OP_WAIT_IRQ && !pg2_reg) ? ST_WAIT : ST_IDLE; // RQ11
                end
                // sleep lasts until an interrupt shows up on a bus clock
                ST_WAIT: if (wake) state_reg <= ST_IDLE;                           // RQ11
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // index halves: upper cleared by reset, lower kept
    // ------------------------------------------------------------
    // the upper half only moves on the stack-to-pointer transfer
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) high_reg <= HIGH_RESET;                                       // RQ6
        else if (exec_end && !pg2_reg && op_reg == OP_STACK_TO_PTR)
            high_reg <= ptr_inc[15:8];                                             // RQ9
    end

    // no reset here on purpose: the lower half must keep its value through reset
    always_ff @(posedge mclk) begin
        if (exec_end && !pg2_reg) begin
            if (op_reg == OP_ACC_TO_LOW) low_reg <= regs_in.acc;                   // RQ7 RQ5 RQ3
            else if (op_reg == OP_STACK_TO_PTR) low_reg <= ptr_inc[7:0];           // RQ9
            else if (low_alu_hit) low_reg <= low_alu;                              // RQ3
        end
    end

    // ------------------------------------------------------------
    // register image outputs
    // ------------------------------------------------------------
    // every output is registered, so each shows one clock after the internal state;
    // the image passes regs_in through; effects land in the done cycle, and the wait opcode also clears the mask as it goes to sleep
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            regs_out   <= '0;
            index_high <= HIGH_RESET;
            index_low  <= BYTE_ZERO;
            eff_addr   <= '0;
            busy       <= 1'b0;
            halted     <= 1'b0;
            done       <= 1'b0;
        end else begin
            index_high <= high_reg;
            index_low  <= low_reg;
            // the direct form uses the operand byte as a low-page address
            eff_addr   <= (op_reg == OP_TEST_DIR && !pg2_reg) ? {8'h00, opnd_reg} :
                          (pg2_reg ? regs_in.stack_pointer + {8'h00, offset8} : ix_addr); // RQ2
            busy       <= (state_reg != ST_IDLE) || start;
            // halted drops in the wake cycle so it never overlaps done
            halted     <= (state_reg == ST_WAIT) && !wake;
            done       <= (exec_end && !(op_reg == OP_WAIT_IRQ && !pg2_reg))
                          || wake;
            // pass-through first; the branches below override single fields
            regs_out   <= regs_in;
            if (exec_end) begin
                if (is_test) begin
                    regs_out.cc[CC_V] <= 1'b0;                                     // RQ8
                    regs_out.cc[CC_N] <= test_val[7];                              // RQ8
                    regs_out.cc[CC_Z] <= (test_val == BYTE_ZERO);                  // RQ8
                end else if (!pg2_reg) begin
                    case (op_reg)
                        OP_ACC_TO_FLAGS: regs_out.cc <= regs_in.acc | CC_FIXED_ONES; // RQ13
                        OP_FLAGS_TO_ACC: regs_out.acc <= regs_in.cc;               // RQ13
                        OP_LOW_TO_ACC:   regs_out.acc <= low_reg;                  // RQ14 RQ5
                        OP_PTR_TO_STACK: regs_out.stack_pointer <= ptr_dec;        // RQ10
                        OP_WAIT_IRQ:     regs_out.cc[CC_I] <= 1'b0;                // RQ11
                        // lower-half data ops set N and Z from their result and C from low_carry
                        default: if (low_alu_hit) begin
                            regs_out.cc[CC_N] <= low_alu[7];
                            regs_out.cc[CC_Z] <= (low_alu == BYTE_ZERO);
                            regs_out.cc[CC_C] <= low_carry;
                        end
                    endcase
                end
            end
            // the wake cycle carries the mask clear, since done only comes then
            if (wake) regs_out.cc[CC_I] <= 1'b0;                                   // RQ11
        end
    end
endmodule : index_reg_transfer_ops

// ### dv/mem_bus_model.sv
// memory side model: returns one byte for each operand address
`timescale 1ns/1ns
module mem_bus_model (
    // bus side
    input  wire logic        sel,
    input  wire logic [15:0] addr,
    output logic [7:0]       data
);
    // ------------------------------------------------------------
    // read data: address pattern while selected; a released bus
    // shows the inverted old byte so a stale sample cannot pass
    // ------------------------------------------------------------
    always @(sel or addr) begin
        if (sel) begin
            data = addr[7:0] ^ addr[15:8] ^ 8'h5a;
        end else begin
            data = ~data;
        end
    end
endmodule : mem_bus_model

// ### dv/idx_ops_checker.sv
// concurrent checks on the ports of the index pointer and transfer unit
`timescale 1ns/1ns
module idx_ops_checker import idx_ops_pkg::*; (
    // clock and reset
    input wire logic       mclk,
    input wire logic       arst_n,
    // request side
    input instr_req_t      req,
    input wire logic       irq_pending,
    input core_regs_t      regs_in,
    // results
    input core_regs_t      regs_out,
    input wire logic [7:0] index_high,
    input wire logic [7:0] index_low,
    input wire logic       busy,
    input wire logic       halted,
    input wire logic       done
);
    // ------------------------------------------------------------
    // all checks on the core clock, quiet while reset is low
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    chk_done_pulse: assert property (done |=> !done)
        else $error("done held longer than one cycle");
    chk_busy_cause: assert property ($rose(busy) |-> $past(req.valid))
        else $error("busy rose without a request");
    chk_done_bound: assert property ($rose(busy) && $past(req.opcode) != OP_WAIT_IRQ
        |-> ##[0:16] done) else $error("instruction did not finish in time");
    chk_high_stable: assert property ($changed(index_high) |-> $past(done) || $past(done, 2))
        else $error("upper index half moved outside an instruction end");
    chk_wait_hold: assert property ((halted && !irq_pending)[*4] |=> !done)
        else $error("wait ended without an interrupt");
    chk_copy_flags: assert property ($rose(busy) && $past(req.opcode) == OP_ACC_TO_LOW
        |-> ##[0:8] done ##0 (regs_out.cc == regs_in.cc && regs_out.acc == regs_in.acc))
        else $error("accumulator copy disturbed flags or accumulator");
    chk_stack_load: assert property ($rose(busy) && $past(req.opcode) == OP_PTR_TO_STACK
        |-> ##[0:12] done ##0 regs_out.stack_pointer == {index_high, index_low} - PTR_STEP)
        else $error("stack pointer not loaded with pointer minus one");
    chk_pointer_load: assert property ($rose(busy) && $past(req.opcode) == OP_STACK_TO_PTR
        |-> ##[0:12] done ##2 {index_high, index_low} == regs_in.stack_pointer + PTR_STEP)
        else $error("pointer not loaded with stack plus one");
    chk_test_acc: assert property ($rose(busy) && $past(req.opcode) == OP_TEST_ACC
        |-> ##[0:8] done ##0 (!regs_out.cc[CC_V] && regs_out.cc[CC_N] == regs_in.acc[7]
        && regs_out.cc[CC_Z] == (regs_in.acc == BYTE_ZERO)))
        else $error("accumulator test flags wrong");
endmodule : idx_ops_checker

bind index_reg_transfer_ops idx_ops_checker u_chk (.mclk, .arst_n, .req, .irq_pending,
    .regs_in, .regs_out, .index_high, .index_low, .busy, .halted, .done);

// ### dv/tb_index_reg_transfer_ops.sv
// self-checking bench for the index pointer and transfer unit
`timescale 1ns/1ns
module tb_index_reg_transfer_ops import idx_ops_pkg::*;;
    typedef struct packed {
        logic [15:0] op;    // prefix byte above opcode
        logic [7:0]  acc;
        logic [7:0]  cc;
        logic [15:0] ea;    // operand address, zero skips the address compare
        logic [7:0]  e_acc;
        logic [7:0]  e_cc;
        logic [15:0] e_ptr;
        logic [1:0]  nb;    // bus cycles, zero skips timing
        logic        ccm;   // flags compared
    } row_t;
    logic        mclk, arst_n, vld, pg, irq, msel, busy, halted, done;
    logic [7:0]  opc, mdat, ihi, ilo;
    logic [15:0] ea, eff;
    core_regs_t  regs_in, regs_out;
    instr_req_t  req;
    wire  [15:0] stk_out = regs_out.stack_pointer;   // stack pointer image out
    int          err_count, compares;
    row_t        rows [21];
    assign req  = '{vld, opc, pg, mdat};
    assign msel = vld | busy;   // memory selected while an instruction runs
    index_reg_transfer_ops DUT (.mclk(mclk), .arst_n(arst_n), .req(req), .irq_pending(irq),
        .regs_in(regs_in), .offset8(8'h10), .regs_out(regs_out), .index_high(ihi),
        .index_low(ilo), .eff_addr(eff), .busy(busy), .halted(halted), .done(done));
    mem_bus_model mem (.sel(msel), .addr(ea), .data(mdat));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // request held one cycle, register image left standing afterwards
    task automatic go(input logic [15:0] op, input logic [7:0] a, input logic [7:0] c);
        @(negedge mclk);
        vld = 1'b1;
        opc = op[7:0];
        pg = (op[15:8] == OP_PAGE2);
        regs_in = '{a, c, 16'h12ff};
        @(negedge mclk);
        vld = 1'b0;
    endtask : go
    task automatic wt(output int n);
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        cmp({15'h0000, done}, 16'h0001);
    endtask : wt
    task automatic run(input row_t r);
        int n;
        ea = r.ea;
        go(r.op, r.acc, r.cc);
        wt(n);
        if (r.nb != 2'd0) begin
            cmp(16'(n >= 2 * r.nb - 1 && n <= 2 * r.nb + 3), 16'h0001);
        end
        cmp({regs_out.acc, regs_out.cc & {8{r.ccm}}}, {r.e_acc, r.e_cc & {8{r.ccm}}});
        cmp(stk_out, r.op[7:0] == OP_PTR_TO_STACK ? r.e_ptr - PTR_STEP : 16'h12ff);
        if (r.ea != 16'h0000) begin
            cmp(eff, r.ea);
        end
        repeat (2) @(negedge mclk);
        cmp({ihi, ilo}, r.e_ptr);
    endtask : run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // clock and watchdog, the run needs well under a thousand cycles
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        close_out();
    end
    // ------------------------------------------------------------
    // table of ordinary cases, then reset and wait by hand
    // ------------------------------------------------------------
    initial begin
        int n;
        {arst_n, vld, pg, irq, opc, ea, regs_in} = '0;
        rows = '{'{16'h0097,8'ha5,8'h68,16'h0000,8'ha5,8'h68,16'h00a5,2'd1,1'b1},
        '{16'h009f,8'h3c,8'h68,16'h0000,8'ha5,8'h68,16'h00a5,2'd1,1'b1},
        '{16'h0095,8'h3c,8'h68,16'h0000,8'h3c,8'h68,16'h1300,2'd2,1'b1},
        '{16'h0085,8'h3c,8'he9,16'h0000,8'he9,8'he9,16'h1300,2'd1,1'b1},
        '{16'h0084,8'h82,8'h68,16'h0000,8'h82,8'he2,16'h1300,2'd1,1'b1},
        '{16'h004d,8'h80,8'hfb,16'h0000,8'h80,8'h7d,16'h1300,2'd1,1'b1},
        '{16'h005d,8'h3c,8'hfb,16'h0000,8'h3c,8'h7b,16'h1300,2'd1,1'b1},
        '{16'h003d,8'h3c,8'hfb,16'h0000,8'h3c,8'h79,16'h1300,2'd0,1'b1},
        '{16'h007d,8'h3c,8'hfb,16'h1300,8'h3c,8'h79,16'h1300,2'd0,1'b1},
        '{16'h006d,8'h3c,8'hfb,16'h1310,8'h3c,8'h79,16'h1300,2'd0,1'b1},
        '{16'h9e6d,8'h3c,8'h64,16'h130f,8'h3c,8'h60,16'h1300,2'd0,1'b1},
        '{16'h005f,8'h3c,8'h68,16'h0000,8'h3c,8'h68,16'h1300,2'd0,1'b0},
        '{16'h005c,8'h3c,8'h68,16'h0000,8'h3c,8'h68,16'h1301,2'd0,1'b0},
        '{16'h005a,8'h3c,8'h68,16'h0000,8'h3c,8'h68,16'h1300,2'd0,1'b0},
        '{16'h0053,8'h3c,8'h68,16'h0000,8'h3c,8'h68,16'h13ff,2'd0,1'b0},
        '{16'h0050,8'h3c,8'h68,16'h0000,8'h3c,8'h68,16'h1301,2'd0,1'b0},
        '{16'h0058,8'h3c,8'h68,16'h0000,8'h3c,8'h68,16'h1302,2'd0,1'b0},
        '{16'h0054,8'h3c,8'h68,16'h0000,8'h3c,8'h68,16'h1301,2'd0,1'b0},
        '{16'h0059,8'h3c,8'h68,16'h0000,8'h3c,8'h68,16'h1302,2'd0,1'b0},
        '{16'h0056,8'h3c,8'h68,16'h0000,8'h3c,8'h68,16'h1301,2'd0,1'b0},
        '{16'h0094,8'h3c,8'h68,16'h0000,8'h3c,8'h68,16'h1301,2'd2,1'b1}};
        repeat (5) @(negedge mclk);
        arst_n = 1'b1;
        foreach (rows[i]) run(rows[i]);
        // second reset mid-run: upper half cleared, lower half survives
        arst_n = 1'b0;
        #1;
        cmp({ihi, ilo}, 16'h0000);
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        repeat (3) @(negedge mclk);
        cmp({ihi, ilo}, 16'h0001);
        // wait stays halted until the interrupt, mask bit cleared
        go(16'h008f, 8'h3c, 8'h68);
        repeat (20) @(negedge mclk);
        cmp({7'h00, halted, 7'h00, done}, 16'h0100);
        irq = 1'b1;
        wt(n);
        cmp({7'h00, done, regs_out.cc}, 16'h0160);
        irq = 1'b0;
        repeat (2) @(negedge mclk);
        close_out();
    end
endmodule : tb_index_reg_transfer_ops
